// ---- cap_pkg.sv ----
// package: register map, field positions and carriers for the counter array register access
package cap_pkg;
   localparam int NUM_MODULES = 6;
   localparam logic [7:0] ADDR_COUNTER_LOW = 8'h00_F9;
   localparam logic [7:0] ADDR_COUNTER_HIGH = 8'h00_FA;
   localparam logic [7:0] ADDR_VALUE_LOW [NUM_MODULES] = '{8'h00_FB, 8'h00_E9, 8'h00_EB,
      8'h00_ED, 8'h00_FD, 8'h00_D2};
   localparam logic [7:0] ADDR_VALUE_HIGH [NUM_MODULES] = '{8'h00_FC, 8'h00_EA, 8'h00_EC,
      8'h00_EE, 8'h00_FE, 8'h00_D3};
   localparam logic [7:0] BYTE_RESET = 8'h00_00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] READ_UNMAPPED = 8'h00_00;
   localparam int LOW_LSB = 0;
   localparam int HIGH_LSB = 8;

   // one special function register access from the core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cap_sfr_req_s;

   // per-module state seen by the compare logic
   typedef struct packed {
      logic comparator_enable;
      logic [15:0] module_value;
      logic [15:0] reload_value;
   } cap_module_s;
endpackage

// ---- cap_regs.sv ----
// register access logic for the counter array: counter, snapshot, module and reload values
`timescale 1ns/1ps
`default_nettype none
// Contract
// - counter as two cleared read/write bytes
// - high read returns snapshot taken at low read
// - watchdog on blocks counter low writes
// - watchdog on blocks counter high writes
// - six modules with cleared 16-bit value bytes
// - low address also reaches reload low byte
// - high address also reaches reload high byte
// - reload select steers module byte accesses
// - low byte write clears comparator enable
// - high byte write sets comparator enable
// - comparator enable turns compare function on
module cap_regs (
   input wire logic clk,
   input wire logic reset_n,
   input wire cap_pkg::cap_sfr_req_s sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic watchdog_enable,
   input wire logic reload_select,
   input wire logic counter_tick,
   input wire logic [cap_pkg::NUM_MODULES-1:0] mode_write,
   input wire logic [cap_pkg::NUM_MODULES-1:0] mode_comparator_enable,
   output logic [15:0] array_counter_value,
   output cap_pkg::cap_module_s [cap_pkg::NUM_MODULES-1:0] module_state,
   output logic [cap_pkg::NUM_MODULES-1:0] compare_active
);
   logic [15:0] counter;
   logic [15:0] next_counter;
   logic [7:0] snapshot;
   logic [7:0] next_snapshot;
   logic [7:0] next_rdata;
   logic [15:0] value [cap_pkg::NUM_MODULES];
   logic [15:0] reload [cap_pkg::NUM_MODULES];
   logic [cap_pkg::NUM_MODULES-1:0] cmp_en;
   logic [15:0] next_value [cap_pkg::NUM_MODULES];
   logic [15:0] next_reload [cap_pkg::NUM_MODULES];
   logic [cap_pkg::NUM_MODULES-1:0] next_cmp_en;
   logic wr_low;
   logic wr_high;

   ////////////////////////////////////////////////////////////////////////////////
   // counter and snapshot
   always_comb begin
      wr_low = sfr_req.wr && (sfr_req.addr == cap_pkg::ADDR_COUNTER_LOW);
      wr_high = sfr_req.wr && (sfr_req.addr == cap_pkg::ADDR_COUNTER_HIGH);
      next_counter = counter + 16'(counter_tick);
      // software writes win over the count, but not while the watchdog owns the counter
      if (wr_low && !watchdog_enable) begin
         next_counter[cap_pkg::LOW_LSB +: 8] = sfr_req.wdata;
      end
      if (wr_high && !watchdog_enable) begin
         next_counter[cap_pkg::HIGH_LSB +: 8] = sfr_req.wdata;
      end
      next_snapshot = snapshot;
      if (sfr_req.rd && (sfr_req.addr == cap_pkg::ADDR_COUNTER_LOW)) begin
         next_snapshot = counter[cap_pkg::HIGH_LSB +: 8];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         counter <= cap_pkg::WORD_RESET;
         snapshot <= cap_pkg::BYTE_RESET;
      end else begin
         counter <= next_counter;
         snapshot <= next_snapshot;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // module value, reload value and comparator enable
   for (genvar m = 0; m < cap_pkg::NUM_MODULES; m++) begin : g_module
      logic hit_low;
      logic hit_high;
      assign hit_low = sfr_req.wr && (sfr_req.addr == cap_pkg::ADDR_VALUE_LOW[m]);
      assign hit_high = sfr_req.wr && (sfr_req.addr == cap_pkg::ADDR_VALUE_HIGH[m]);

      always_comb begin
         next_value[m] = value[m];
         next_reload[m] = reload[m];
         next_cmp_en[m] = cmp_en[m];
         if (mode_write[m]) begin
            next_cmp_en[m] = mode_comparator_enable[m];
         end
         if (hit_low) begin
            if (reload_select) begin
               next_reload[m][cap_pkg::LOW_LSB +: 8] = sfr_req.wdata;
            end else begin
               next_value[m][cap_pkg::LOW_LSB +: 8] = sfr_req.wdata;
            end
            next_cmp_en[m] = 1'b0;
         end
         if (hit_high) begin
            if (reload_select) begin
               next_reload[m][cap_pkg::HIGH_LSB +: 8] = sfr_req.wdata;
            end else begin
               next_value[m][cap_pkg::HIGH_LSB +: 8] = sfr_req.wdata;
            end
            next_cmp_en[m] = 1'b1;
         end
      end

      always_ff @(posedge clk) begin
         if (!reset_n) begin
            value[m] <= cap_pkg::WORD_RESET;
            reload[m] <= cap_pkg::WORD_RESET;
            cmp_en[m] <= 1'b0;
         end else begin
            value[m] <= next_value[m];
            reload[m] <= next_reload[m];
            cmp_en[m] <= next_cmp_en[m];
         end
      end

      assign module_state[m].comparator_enable = cmp_en[m];
      assign module_state[m].module_value = value[m];
      assign module_state[m].reload_value = reload[m];
      assign compare_active[m] = cmp_en[m];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data, registered one cycle after the read strobe
   always_comb begin
      next_rdata = cap_pkg::READ_UNMAPPED;
      if (sfr_req.addr == cap_pkg::ADDR_COUNTER_LOW) begin
         next_rdata = counter[cap_pkg::LOW_LSB +: 8];
      end else if (sfr_req.addr == cap_pkg::ADDR_COUNTER_HIGH) begin
         next_rdata = snapshot;
      end else begin
         for (int m = 0; m < cap_pkg::NUM_MODULES; m++) begin
            if (sfr_req.addr == cap_pkg::ADDR_VALUE_LOW[m]) begin
               next_rdata = reload_select ? reload[m][cap_pkg::LOW_LSB +: 8]
                                          : value[m][cap_pkg::LOW_LSB +: 8];
            end else if (sfr_req.addr == cap_pkg::ADDR_VALUE_HIGH[m]) begin
               next_rdata = reload_select ? reload[m][cap_pkg::HIGH_LSB +: 8]
                                          : value[m][cap_pkg::HIGH_LSB +: 8];
            end
         end
      end
      if (!sfr_req.rd) begin
         next_rdata = sfr_rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sfr_rdata <= cap_pkg::BYTE_RESET;
      end else begin
         sfr_rdata <= next_rdata;
      end
   end

   assign array_counter_value = counter;
endmodule // cap_regs
`default_nettype wire

// ---- cap_core.sv ----
// processor core model that issues single register accesses
`timescale 1ns/1ps
`default_nettype none
module cap_core (
   input wire logic clk,
   output cap_pkg::cap_sfr_req_s req = '0
);
   task op(input logic rd, input logic [7:0] a, d);
      req <= {rd, !rd, a, d};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask
endmodule // cap_core
`default_nettype wire

// ---- cap_regs_sva.sv ----
// checker on the counter array register access ports
`timescale 1ns/1ps
`default_nettype none
module cap_regs_sva (
   input wire logic clk,
   input wire logic reset_n,
   input wire cap_pkg::cap_sfr_req_s sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic watchdog_enable,
   input wire logic reload_select,
   input wire logic counter_tick,
   input wire logic [15:0] array_counter_value,
   input wire cap_pkg::cap_module_s [5:0] module_state,
   input wire logic [5:0] compare_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire [7:0] a = sfr_req.addr, d = sfr_req.wdata;
   wire [15:0] cv = array_counter_value;
   wire cap_pkg::cap_module_s m = module_state[0];
   wire rl = sfr_req.rd && a == 8'hF9, rh = sfr_req.rd && a == 8'hFA, s = reload_select;
   wire lo = sfr_req.wr && a == 8'hFB, hi = sfr_req.wr && a == 8'hFC;
   wire lk = sfr_req.wr && watchdog_enable && !counter_tick;
   a_snap_read: assert property (rl ##1 !rl ##1 rh |=> sfr_rdata == $past(cv[15:8], 3))
      else $error("snapshot byte wrong");
   a_lock_lo: assert property (lk && a == 8'hF9 |=> $stable(cv[7:0])) else $error("lo moved");
   a_lock_hi: assert property (lk && a == 8'hFA |=> $stable(cv[15:8])) else $error("hi moved");
   a_lo_clr: assert property (lo |=> !compare_active[0]) else $error("enable kept");
   a_hi_set: assert property (hi |=> m.comparator_enable) else $error("enable off");
   a_en_out: assert property (compare_active[0] == m.comparator_enable) else $error("en");
   a_val_lo: assert property (lo && !s |=> m.module_value[7:0] == $past(d)) else $error("v");
   a_rl_lo: assert property (lo && s |=> m.reload_value[7:0] == $past(d)) else $error("r");
   a_rl_hi: assert property (hi && s |=> m.reload_value[15:8] == $past(d)) else $error("rh");
   a_rd_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata)) else $error("rdata moved");
endmodule // cap_regs_sva
bind cap_regs cap_regs_sva u_sva (.clk, .reset_n, .sfr_req, .sfr_rdata, .watchdog_enable,
   .reload_select, .counter_tick, .array_counter_value, .module_state, .compare_active);
`default_nettype wire

// ---- counter_array_register_access_bench.sv ----
// self-checking bench for the counter array register access
`timescale 1ns/1ps
`default_nettype none
module counter_array_register_access_bench;
   logic clk = 0, reset_n = 0, watchdog_enable = 0, reload_select = 0;
   logic [7:0] sfr_rdata;
   cap_pkg::cap_sfr_req_s sfr_req;
   cap_pkg::cap_module_s [5:0] module_state;
   logic counter_tick = 0;
   logic [5:0] mode_write = 6'h00, mode_comparator_enable = 6'h00, compare_active;
   logic [15:0] array_counter_value;
   int n_fail = 0, comparisons = 0;
   always #2 clk = ~clk;
   initial #4000 end_of_test(1);
   cap_core core (.clk, .req(sfr_req));
   cap_regs DUT (.clk, .reset_n, .sfr_req, .sfr_rdata, .watchdog_enable, .reload_select,
      .counter_tick, .mode_write, .mode_comparator_enable, .array_counter_value,
      .module_state, .compare_active);
   task chk(input string n, input logic [15:0] s, e);
      comparisons++;
      if (s !== e) $display("MISMATCH %s expected %h seen %h", n, e, s);
      n_fail += (s !== e);
   endtask
   task rd(input string n, input logic [7:0] a, e);
      core.op(1, a, 8'h00);
      chk(n, sfr_rdata, e);
   endtask
   task end_of_test(input int extra);
      n_fail += extra;
      if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task t_counter;
      rd("rst", 8'hF9, 8'h00);
      core.op(0, 8'hF9, 8'h34);
      core.op(0, 8'hFA, 8'h12);
      watchdog_enable <= 1;
      core.op(0, 8'hF9, 8'hAA);
      core.op(0, 8'hFA, 8'hBB);
      watchdog_enable <= 0;
      rd("lo", 8'hF9, 8'h34);
      rd("hi", 8'hFA, 8'h12);
      core.op(0, 8'hFA, 8'h56);
      rd("snap", 8'hFA, 8'h12);
      core.op(0, 8'hF9, 8'hFF);
      counter_tick <= 1;
      rd("tick_lo", 8'hF9, 8'hFF);
      counter_tick <= 0;
      rd("tick_hi", 8'hFA, 8'h56);
      chk("count", array_counter_value, 16'h5701);
   endtask
   task t_mode_reset;
      mode_comparator_enable <= 6'h15;
      mode_write <= 6'h3F;
      @(posedge clk);
      mode_write <= 6'h00;
      @(posedge clk);
      chk("mode", compare_active, 6'h15);
      reset_n <= 0;
      repeat (2) @(posedge clk);
      reset_n <= 1;
      @(posedge clk);
      chk("rst_cnt", array_counter_value, 16'h0000);
      chk("rst_val", module_state[5].module_value, 16'h0000);
      chk("rst_en", compare_active, 6'h00);
      rd("rst_snap", 8'hFA, 8'h00);
   endtask
   task t_modules;
      for (int i = 0; i < 6; i++) begin
         rd("rst", cap_pkg::ADDR_VALUE_HIGH[i], 8'h00);
         core.op(0, cap_pkg::ADDR_VALUE_LOW[i], 8'h10);
         core.op(0, cap_pkg::ADDR_VALUE_HIGH[i], 8'h20);
         chk("en_hi", module_state[i].comparator_enable, 1'b1);
         reload_select <= 1;
         core.op(0, cap_pkg::ADDR_VALUE_LOW[i], 8'h30);
         chk("en_lo", module_state[i].comparator_enable, 1'b0);
         core.op(0, cap_pkg::ADDR_VALUE_HIGH[i], 8'h40);
         chk("act_hi", compare_active[i], 1'b1);
         rd("rl", cap_pkg::ADDR_VALUE_LOW[i], 8'h30);
         rd("rh", cap_pkg::ADDR_VALUE_HIGH[i], 8'h40);
         reload_select <= 0;
         rd("cc", cap_pkg::ADDR_VALUE_LOW[i], 8'h10);
         rd("cch", cap_pkg::ADDR_VALUE_HIGH[i], 8'h20);
      end
      rd("none", 8'h00, cap_pkg::READ_UNMAPPED);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1;
      @(posedge clk);
      t_counter;
      t_modules;
      t_mode_reset;
      end_of_test(0);
   end
endmodule // counter_array_register_access_bench
`default_nettype wire
